// >>> src/rtd_dev.sv
// Channel end: parameters, scaling, range, format and compensation
`timescale 1ns/1ps
`default_nettype none
module rtd_dev #(
    parameter int STEP_FAST_CYC = rtd_pkg::STEP_FAST_CYC,
    parameter int STEP_SLOW_CYC = rtd_pkg::STEP_SLOW_CYC
) (
    input wire logic mclk,                    // Clock
    input wire logic rst_n,                   // Async reset, active low
    rtd_link_if.dev link,                     // Link to controller
    input wire logic signed [15:0] adc_raw,   // Raw conversion result
    input wire logic [15:0] line_raw,         // Raw line resistance
    input wire logic adc_valid,               // New conversion, pulse
    input wire logic adc_error,               // Front-end fault
    output logic [15:0] pv,                   // Process value
    output logic pv_valid,                    // New process value, pulse
    output logic [1:0] conv_sel,              // Conversion time select
    output logic wdog_en,                     // Watchdog enable
    output logic two_wire_en,                 // Two-wire mode
    output logic param_commit                 // Store parameters, pulse
);
    logic [15:0] hw_off_q, hw_gain_q, vend_off_q, vend_gain_q, two_wire_q;
    logic [15:0] mode_q, user_off_q, user_gain_q, filter_q, unlock_q;
    logic [7:0] ctrl_q;
    logic [15:0] rdata;
    logic unlocked, was_unlocked_q, wr_req, comp_on, step;
    logic [27:0] step_cnt_q;
    logic [3:0] elem;
    logic signed [23:0] x_adj, r16, r_min, r_max, r_lim, v_vend, v_user;
    logic signed [40:0] r_prod;
    logic over, under;
    logic signed [15:0] v16;
    logic [15:0] word;

    assign unlocked = (unlock_q == rtd_pkg::UNLOCK_CODE);
    assign wr_req = link.stb && link.ctrl[rtd_pkg::CB_REG] && link.ctrl[rtd_pkg::CB_WR];
    assign comp_on = unlocked && !ctrl_q[rtd_pkg::CB_REG] && ctrl_q[rtd_pkg::CB_WR];
    assign elem = mode_q[rtd_pkg::MB_ELEM_LO +: 4];

    // Latest control byte steers compensation
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= 8'h00;
        end else if (link.stb) begin
            ctrl_q <= link.ctrl;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            step_cnt_q <= 28'h0000000;
        end else if (!comp_on || step) begin
            step_cnt_q <= 28'h0000000;
        end else begin
            step_cnt_q <= step_cnt_q + 28'h0000001;
        end
    end
    assign step = comp_on && (step_cnt_q == (ctrl_q[rtd_pkg::CB_FAST] ? 28'(STEP_FAST_CYC - 1)
                                                                   : 28'(STEP_SLOW_CYC - 1)));

    // Hardware compensation registers, written by link or stepped by compensation
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hw_off_q <= rtd_pkg::RST_HW_OFF;
            hw_gain_q <= rtd_pkg::RST_HW_GAIN;
        end else if (wr_req && unlocked && link.ctrl[5:0] == rtd_pkg::REG_HW_OFF) begin
            hw_off_q <= link.dout;
        end else if (wr_req && unlocked && link.ctrl[5:0] == rtd_pkg::REG_HW_GAIN) begin
            hw_gain_q <= link.dout;
        end else if (step && (ctrl_q[rtd_pkg::CB_UP] != ctrl_q[rtd_pkg::CB_DOWN])) begin
            if (ctrl_q[rtd_pkg::CB_GAIN]) begin
                hw_gain_q <= ctrl_q[rtd_pkg::CB_UP] ? hw_gain_q + 16'h0001 : hw_gain_q - 16'h0001;
            end
            if (ctrl_q[rtd_pkg::CB_OFFS]) begin
                hw_off_q <= ctrl_q[rtd_pkg::CB_UP] ? hw_off_q + 16'h0001 : hw_off_q - 16'h0001;
            end
        end
    end

    // Parameter registers, protected by the unlock code
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            vend_off_q <= rtd_pkg::RST_VEND_OFF;
            vend_gain_q <= rtd_pkg::RST_VEND_GAIN;
            two_wire_q <= rtd_pkg::RST_TWO_WIRE;
            mode_q <= rtd_pkg::RST_MODE;
            user_off_q <= rtd_pkg::RST_USER_OFF;
            user_gain_q <= rtd_pkg::RST_USER_GAIN;
            filter_q <= rtd_pkg::RST_FILTER;
        end else if (wr_req && unlocked) begin
            case (link.ctrl[5:0])
                rtd_pkg::REG_VEND_OFF: vend_off_q <= link.dout;
                rtd_pkg::REG_VEND_GAIN: vend_gain_q <= link.dout;
                rtd_pkg::REG_TWO_WIRE: two_wire_q <= link.dout;
                rtd_pkg::REG_MODE: mode_q <= link.dout;
                rtd_pkg::REG_USER_OFF: user_off_q <= link.dout;
                rtd_pkg::REG_USER_GAIN: user_gain_q <= link.dout;
                rtd_pkg::REG_FILTER: filter_q <= link.dout;
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            unlock_q <= 16'h0000;
        end else if (wr_req && link.ctrl[5:0] == rtd_pkg::REG_UNLOCK) begin
            unlock_q <= link.dout;
        end
    end

    // Leaving the unlocked state stores the parameters
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            was_unlocked_q <= 1'b0;
            param_commit <= 1'b0;
        end else begin
            was_unlocked_q <= unlocked;
            param_commit <= was_unlocked_q && !unlocked;
        end
    end

    always_comb begin
        case (link.ctrl[5:0])
            rtd_pkg::REG_RAW: rdata = adc_raw;
            rtd_pkg::REG_LINE: rdata = line_raw;
            rtd_pkg::REG_HW_OFF: rdata = hw_off_q;
            rtd_pkg::REG_HW_GAIN: rdata = hw_gain_q;
            rtd_pkg::REG_VEND_OFF: rdata = vend_off_q;
            rtd_pkg::REG_VEND_GAIN: rdata = vend_gain_q;
            rtd_pkg::REG_TWO_WIRE: rdata = two_wire_q;
            rtd_pkg::REG_UNLOCK: rdata = unlocked ? unlock_q : 16'h0000;
            rtd_pkg::REG_MODE: rdata = mode_q;
            rtd_pkg::REG_USER_OFF: rdata = user_off_q;
            rtd_pkg::REG_USER_GAIN: rdata = user_gain_q;
            rtd_pkg::REG_FILTER: rdata = filter_q;
            default: rdata = 16'h0000;
        endcase
    end

    // Element range in 1/16 ohm
    always_comb begin
        case (elem)
            rtd_pkg::EL_PT100, rtd_pkg::EL_NI100: begin r_min = 24'sd200; r_max = 24'sd6400; end
            rtd_pkg::EL_PT1000, rtd_pkg::EL_NI1000: begin r_min = 24'sd2000; r_max = 24'sd64000; end
            rtd_pkg::EL_PT500: begin r_min = 24'sd1000; r_max = 24'sd32000; end
            rtd_pkg::EL_PT200: begin r_min = 24'sd400; r_max = 24'sd12800; end
            rtd_pkg::EL_NI120: begin r_min = 24'sd240; r_max = 24'sd7680; end
            rtd_pkg::EL_OHM5K: begin r_min = rtd_pkg::OHM_MIN; r_max = rtd_pkg::OHM5K_MAX; end
            rtd_pkg::EL_OHM1K2: begin r_min = rtd_pkg::OHM_MIN; r_max = rtd_pkg::OHM1K2_MAX; end
            default: begin r_min = rtd_pkg::OHM_MIN; r_max = rtd_pkg::OHM5K_MAX; end
        endcase
    end

    // One compensation pair feeds every element
    always_comb begin
        x_adj = mode_q[rtd_pkg::MB_TWO_WIRE] ? 24'(adc_raw) - 24'($signed(two_wire_q)) : 24'(adc_raw);
        r_prod = (41'(x_adj) + 41'($signed(hw_off_q))) * 41'($signed({1'b0, hw_gain_q}));
        r16 = 24'(r_prod >>> rtd_pkg::HW_GAIN_SHIFT) + rtd_pkg::AXIS_100;
        over = r16 > r_max;
        under = r16 < r_min;
        r_lim = (over && mode_q[rtd_pkg::MB_CLAMP]) ? r_max : r16;
    end

    rtd_line u_vend (
        .en(mode_q[rtd_pkg::MB_VEND]),
        .x(r_lim),
        .off(vend_off_q),
        .gain(vend_gain_q),
        .y(v_vend)
    );

    rtd_line u_user (
        .en(mode_q[rtd_pkg::MB_USER]),
        .x(v_vend),
        .off(user_off_q),
        .gain(user_gain_q),
        .y(v_user)
    );

    // Output word: saturate, sign-magnitude, packed status
    always_comb begin
        if (mode_q[rtd_pkg::MB_PACKED]) begin
            v16 = (v_user > 24'sd4095) ? 16'sd4095 : (v_user < -24'sd4095) ? -16'sd4095 : v_user[15:0];
        end else begin
            v16 = (v_user > 24'sd32767) ? 16'sd32767 : (v_user < -24'sd32767) ? -16'sd32767 : v_user[15:0];
        end
        word = v16;
        if (mode_q[rtd_pkg::MB_SIGNMAG] && v16[15]) begin
            word = {1'b1, 15'(-v16)};
        end
        if (mode_q[rtd_pkg::MB_PACKED]) begin
            word = {word[15], word[11:0], 1'b0, adc_error, over || under};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pv <= 16'h0000;
            pv_valid <= 1'b0;
        end else begin
            pv_valid <= adc_valid;
            if (adc_valid) begin
                pv <= word;
            end
        end
    end

    // Range flags follow the latest conversion
    logic over_q, under_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            over_q <= 1'b0;
            under_q <= 1'b0;
        end else if (adc_valid) begin
            over_q <= over;
            under_q <= under;
        end
    end

    // Input image answers each output-image update
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            link.stat <= 8'h00;
            link.din <= 16'h0000;
            link.upd <= 1'b0;
        end else begin
            link.upd <= link.stb;
            if (link.stb && link.ctrl[rtd_pkg::CB_REG]) begin
                link.stat <= link.ctrl & 8'hbf;
                link.din <= link.ctrl[rtd_pkg::CB_WR] ? 16'h0000 : rdata;
            end else if (link.stb) begin
                link.stat <= {1'b0, adc_error, 4'h0, over_q, under_q};
                link.din <= pv;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            conv_sel <= rtd_pkg::CONV_250MS;
            wdog_en <= 1'b1;
            two_wire_en <= 1'b0;
        end else begin
            wdog_en <= mode_q[rtd_pkg::MB_WDOG];
            two_wire_en <= mode_q[rtd_pkg::MB_TWO_WIRE];
            if (!mode_q[rtd_pkg::MB_FILTER]) begin
                conv_sel <= rtd_pkg::CONV_250MS;
            end else begin
                case (filter_q)
                    rtd_pkg::FLT_65: conv_sel <= rtd_pkg::CONV_65MS;
                    rtd_pkg::FLT_125: conv_sel <= rtd_pkg::CONV_125MS;
                    rtd_pkg::FLT_500: conv_sel <= rtd_pkg::CONV_500MS;
                    rtd_pkg::FLT_250, rtd_pkg::FLT_DEF: conv_sel <= rtd_pkg::CONV_250MS;
                    default: conv_sel <= rtd_pkg::CONV_250MS;
                endcase
            end
        end
    end
endmodule // rtd_dev
`default_nettype wire

// >>> src/rtd_pkg.sv
// Shared constants for the resistance-thermometer channel and its controller
package rtd_pkg;
    localparam logic [5:0] REG_RAW = 6'h00;
    localparam logic [5:0] REG_LINE = 6'h01;
    localparam logic [5:0] REG_HW_OFF = 6'h11;
    localparam logic [5:0] REG_HW_GAIN = 6'h12;
    localparam logic [5:0] REG_VEND_OFF = 6'h13;
    localparam logic [5:0] REG_VEND_GAIN = 6'h14;
    localparam logic [5:0] REG_TWO_WIRE = 6'h15;
    localparam logic [5:0] REG_UNLOCK = 6'h1f;
    localparam logic [5:0] REG_MODE = 6'h20;
    localparam logic [5:0] REG_USER_OFF = 6'h21;
    localparam logic [5:0] REG_USER_GAIN = 6'h22;
    localparam logic [5:0] REG_SPARE_A = 6'h23;
    localparam logic [5:0] REG_SPARE_B = 6'h24;
    localparam logic [5:0] REG_FILTER = 6'h25;

    localparam logic [15:0] RST_HW_OFF = 16'hed68;
    localparam logic [15:0] RST_HW_GAIN = 16'h4e20;
    localparam logic [15:0] RST_VEND_OFF = 16'h0000;
    localparam logic [15:0] RST_VEND_GAIN = 16'h00a0;
    localparam logic [15:0] RST_TWO_WIRE = 16'h0000;
    localparam logic [15:0] RST_MODE = 16'h0106;
    localparam logic [15:0] RST_USER_OFF = 16'h0000;
    localparam logic [15:0] RST_USER_GAIN = 16'h0100;
    localparam logic [15:0] RST_FILTER = 16'h0000;
    localparam logic [15:0] UNLOCK_CODE = 16'h1235;

    // Mode word fields
    localparam int MB_USER = 0;
    localparam int MB_VEND = 1;
    localparam int MB_WDOG = 2;
    localparam int MB_SIGNMAG = 3;
    localparam int MB_PACKED = 4;
    localparam int MB_FILTER = 7;
    localparam int MB_CLAMP = 8;
    localparam int MB_TWO_WIRE = 10;
    localparam int MB_ELEM_LO = 12;

    // Control byte fields
    localparam int CB_REG = 7;
    localparam int CB_WR = 6;
    localparam int CB_GAIN = 4;
    localparam int CB_OFFS = 3;
    localparam int CB_FAST = 2;
    localparam int CB_UP = 1;
    localparam int CB_DOWN = 0;

    // Status byte fields
    localparam int SB_ERR = 6;
    localparam int SB_OVER = 1;
    localparam int SB_UNDER = 0;

    // Elements
    localparam logic [3:0] EL_PT100 = 4'h0;
    localparam logic [3:0] EL_NI100 = 4'h1;
    localparam logic [3:0] EL_PT1000 = 4'h2;
    localparam logic [3:0] EL_PT500 = 4'h3;
    localparam logic [3:0] EL_PT200 = 4'h4;
    localparam logic [3:0] EL_NI1000 = 4'h5;
    localparam logic [3:0] EL_NI120 = 4'h6;
    localparam logic [3:0] EL_OHM5K = 4'he;
    localparam logic [3:0] EL_OHM1K2 = 4'hf;

    // Resistances in 1/16 ohm
    localparam logic signed [23:0] AXIS_100 = 24'sh000640;
    localparam logic signed [23:0] OHM_MIN = 24'sh0000a0;
    localparam logic signed [23:0] OHM5K_MAX = 24'sh013880;
    localparam logic signed [23:0] OHM1K2_MAX = 24'sh004b00;
    localparam int HW_GAIN_SHIFT = 16;
    localparam int LINE_SHIFT = 8;

    // Filter codes
    localparam logic [15:0] FLT_DEF = 16'h0000;
    localparam logic [15:0] FLT_65 = 16'h0050;
    localparam logic [15:0] FLT_125 = 16'h00a0;
    localparam logic [15:0] FLT_250 = 16'h0140;
    localparam logic [15:0] FLT_500 = 16'h0280;
    typedef enum logic [1:0] {CONV_65MS, CONV_125MS, CONV_250MS, CONV_500MS} rtd_conv_t;

    // Compensation step periods
    localparam int CLK_KHZ = 200000;
    localparam int STEP_FAST_MS = 50;
    localparam int STEP_SLOW_MS = 1000;
    localparam int STEP_FAST_CYC = STEP_FAST_MS * CLK_KHZ;
    localparam int STEP_SLOW_CYC = STEP_SLOW_MS * CLK_KHZ;

    // Controller APB map
    localparam logic [7:0] APB_CMD = 8'h00;
    localparam logic [7:0] APB_RESP = 8'h04;
    localparam logic [7:0] APB_FLAGS = 8'h08;
endpackage

// >>> src/rtd_link_if.sv
// Process-image link between channel and controller
`timescale 1ns/1ps
`default_nettype none
interface rtd_link_if;
    logic stb;          // Controller output image updated, one cycle
    logic [7:0] ctrl;   // Control byte
    logic [15:0] dout;  // Output data word
    logic [7:0] stat;   // Status byte
    logic [15:0] din;   // Input data word
    logic upd;          // Input image updated, one cycle
    modport dev (input stb, input ctrl, input dout, output stat, output din, output upd);
    modport ctl (output stb, output ctrl, output dout, input stat, input din, input upd);
endinterface
`default_nettype wire

// >>> src/rtd_line.sv
// Straight-line scaling stage with saturation
`timescale 1ns/1ps
`default_nettype none
module rtd_line (
    input wire logic en,                 // Stage active
    input wire logic signed [23:0] x,    // Input value
    input wire logic signed [15:0] off,  // Offset
    input wire logic signed [15:0] gain, // Gain, weighted 2^-8
    output logic signed [23:0] y         // Scaled value
);
    logic signed [40:0] prod;
    logic signed [40:0] shr;
    always_comb begin
        prod = (41'(x) + 41'(off)) * 41'(gain);
        shr = prod >>> rtd_pkg::LINE_SHIFT;
        if (!en) begin
            y = x;
        end else if (shr > 41'sd8388607) begin
            y = 24'sh7fffff;
        end else if (shr < -41'sd8388608) begin
            y = 24'sh800000;
        end else begin
            y = shr[23:0];
        end
    end
endmodule // rtd_line
`default_nettype wire

// >>> src/rtd_ctl.sv
// Controller end: APB-programmed link master
`timescale 1ns/1ps
`default_nettype none
module rtd_ctl (
    input wire logic mclk,           // Clock
    input wire logic rst_n,          // Async reset, active low
    rtd_link_if.ctl link,            // Link to channel
    input wire logic psel,           // APB select
    input wire logic penable,        // APB enable
    input wire logic pwrite,         // APB write
    input wire logic [7:0] paddr,    // APB byte address
    input wire logic [31:0] pwdata,  // APB write data
    output logic [31:0] prdata,      // APB read data
    output logic pready,             // APB ready
    output logic pslverr             // APB error
);
    logic acc, wr_cmd, rd_resp, wr_flags, mapped, resp_rdy_q;
    logic [31:0] resp_q;

    assign acc = psel && !penable;
    assign mapped = (paddr == rtd_pkg::APB_CMD) || (paddr == rtd_pkg::APB_RESP) || (paddr == rtd_pkg::APB_FLAGS);
    assign wr_cmd = psel && penable && pready && pwrite && (paddr == rtd_pkg::APB_CMD);
    assign rd_resp = psel && penable && pready && !pwrite && (paddr == rtd_pkg::APB_RESP);
    assign wr_flags = psel && penable && pready && pwrite && (paddr == rtd_pkg::APB_FLAGS);

    // One-cycle access phase
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= acc;
            pslverr <= acc && !mapped;
            if (acc && !pwrite) begin
                case (paddr)
                    rtd_pkg::APB_CMD: prdata <= {link.dout, 8'h00, link.ctrl};
                    rtd_pkg::APB_RESP: prdata <= resp_q;
                    rtd_pkg::APB_FLAGS: prdata <= {31'h00000000, resp_rdy_q};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Software composes unlock, register and compensation bytes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            link.ctrl <= 8'h00;
            link.dout <= 16'h0000;
            link.stb <= 1'b0;
        end else begin
            link.stb <= wr_cmd;
            if (wr_cmd) begin
                link.ctrl <= pwdata[7:0];
                link.dout <= pwdata[31:16];
            end
        end
    end

    // Response capture; a new answer wins over a clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            resp_q <= 32'h00000000;
            resp_rdy_q <= 1'b0;
        end else begin
            if (link.upd) begin
                resp_q <= {link.din, 8'h00, link.stat};
            end
            if (link.upd) begin
                resp_rdy_q <= 1'b1;
            end else if (rd_resp || (wr_flags && pwdata[0])) begin
                resp_rdy_q <= 1'b0;
            end
        end
    end
endmodule // rtd_ctl
`default_nettype wire

// >>> testbench/rtd_link_checker.sv
// Link protocol checks between channel and controller
`timescale 1ns/1ps
`default_nettype none
module rtd_link_checker (
    input wire logic mclk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic stb, // Request strobe
    input wire logic [7:0] ctrl, // Control byte
    input wire logic [15:0] dout, // Output word
    input wire logic [7:0] stat, // Status byte
    input wire logic [15:0] din, // Input word
    input wire logic upd // Answer strobe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_reg_req;
        stb && ctrl[7];
    endsequence
    sequence s_proc_req;
        stb && !ctrl[7];
    endsequence
    a_upd_follows: assert property (stb |=> upd) else $error("no answer after request");
    a_upd_cause: assert property (upd |-> $past(stb)) else $error("answer without request");
    a_reg_echo: assert property (s_reg_req |=> stat == ($past(ctrl) & 8'hbf)) else $error("bad echo");
    a_proc_top: assert property (s_proc_req |=> !stat[7]) else $error("status top bit set");
    a_proc_rsvd: assert property (s_proc_req |=> stat[5:2] == 4'h0) else $error("reserved status set");
    a_stat_hold: assert property (!stb |=> $stable(stat) && $stable(din)) else $error("answer moved");
    a_wr_zero: assert property (s_reg_req ##0 ctrl[6] |=> din == 16'h0000) else $error("write data echoed");
    a_code_read: assert property (stb && ctrl == 8'h9f |=> din == 16'h0000 || din == 16'h1235)
        else $error("bad code word read");
endmodule // rtd_link_checker
`default_nettype wire

// >>> testbench/tb_top.sv
// Testbench joining channel and controller over the link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, adc_valid = 1'b0, adc_error = 1'b0, pv_valid, wdog_en, two_wire_en, param_commit;
    logic signed [15:0] adc_raw = 16'sh0000;
    logic [15:0] line_raw = 16'h0000, pv;
    logic [1:0] conv_sel;
    int error_cnt = 0, checks = 0, commits = 0;
    logic [5:0] ra [8] = '{6'h11, 6'h12, 6'h13, 6'h14, 6'h20, 6'h21, 6'h22, 6'h25};
    logic [15:0] rv [8] = '{16'hed68, 16'h4e20, 16'h0, 16'h00a0, 16'h0106, 16'h0, 16'h0100, 16'h0};
    logic [15:0] cm [10] = '{16'h0, 16'h0, 16'h0100, 16'h0, 16'h0008, 16'h0010, 16'he000, 16'h0002, 16'h0001, 16'h0};
    logic [15:0] cx [10] = '{16'h0, 16'h4000, 16'h4000, 16'hc000, 16'hc000, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    logic [15:0] cp [10] = '{16'h0640, 16'h19c8, 16'h1900, 16'hf2b8, 16'h8d48, 16'h3200, 16'h0640, 16'h03e8,
        16'h0320, 16'h0640};
    logic [7:0] cs [10] = '{8'h0, 8'h02, 8'h02, 8'h01, 8'h01, 8'h0, 8'h0, 8'h0, 8'h0, 8'h40};
    logic [15:0] fc [4] = '{16'h0050, 16'h00a0, 16'h0140, 16'h0280};
    rtd_link_if link ();
    rtd_dev #(.STEP_FAST_CYC(4), .STEP_SLOW_CYC(8)) i_rtd_dev (.mclk(mclk), .rst_n(rst_n), .link(link),
        .adc_raw(adc_raw), .line_raw(line_raw), .adc_valid(adc_valid), .adc_error(adc_error), .pv(pv),
        .pv_valid(pv_valid), .conv_sel(conv_sel), .wdog_en(wdog_en), .two_wire_en(two_wire_en),
        .param_commit(param_commit));
    rtd_ctl i_rtd_ctl (.mclk(mclk), .rst_n(rst_n), .link(link), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    rtd_link_checker i_rtd_link_checker (.mclk(mclk), .rst_n(rst_n), .stb(link.stb), .ctrl(link.ctrl),
        .dout(link.dout), .stat(link.stat), .din(link.din), .upd(link.upd));
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) if (param_commit === 1'b1) commits++;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic lnk(input logic [7:0] c, input logic [15:0] d);
        int n = 0;
        apb(1'b1, rtd_pkg::APB_CMD, {d, 8'h00, c});
        do begin
            apb(1'b0, rtd_pkg::APB_FLAGS, 32'h0);
            n++;
        end while (rd[0] !== 1'b1 && n < 20);
        if (rd[0] !== 1'b1) error_cnt++;
        apb(1'b0, rtd_pkg::APB_RESP, 32'h0);
    endtask
    task automatic rreg(input logic [5:0] a, input logic [15:0] e);
        lnk({2'b10, a}, 16'h0000);
        chk("register read", {e, 8'h00, 2'b10, a}, rd);
    endtask
    task automatic wreg(input logic [5:0] a, input logic [15:0] d);
        lnk({2'b11, a}, d);
        chk("write receipt", {16'h0000, 8'h00, 2'b10, a}, rd);
    endtask
    task automatic conv(input logic [15:0] x, input logic e);
        @(posedge mclk);
        adc_raw <= x;
        adc_error <= e;
        adc_valid <= 1'b1;
        @(posedge mclk);
        adc_valid <= 1'b0;
        @(posedge mclk);
        chk("pv_valid", 32'h1, 32'(pv_valid));
    endtask
    task automatic finish_test();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #50us;
        error_cnt++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk("conv_sel", 32'h2, 32'(conv_sel));
        chk("wdog_en", 32'h1, 32'(wdog_en));
        for (int i = 0; i < 8; i++) rreg(ra[i], rv[i]);
        wreg(rtd_pkg::REG_USER_GAIN, 16'h0080);
        rreg(rtd_pkg::REG_USER_GAIN, 16'h0100);
        lnk(8'h4e, 16'h0000);
        repeat (40) @(posedge mclk);
        rreg(rtd_pkg::REG_HW_OFF, 16'hed68);
        wreg(rtd_pkg::REG_UNLOCK, 16'h1235);
        rreg(rtd_pkg::REG_UNLOCK, 16'h1235);
        wreg(rtd_pkg::REG_HW_OFF, 16'h0000);
        wreg(rtd_pkg::REG_USER_GAIN, 16'h0080);
        for (int i = 0; i < 10; i++) begin
            wreg(rtd_pkg::REG_MODE, cm[i]);
            conv(cx[i], cs[i][6]);
            chk("process value", {16'h0, cp[i]}, {16'h0, pv});
            lnk(8'h00, 16'h0000);
            chk("process reply", {cp[i], 8'h00, cs[i]}, rd);
        end
        wreg(rtd_pkg::REG_MODE, 16'h0080);
        for (int i = 0; i < 4; i++) begin
            wreg(rtd_pkg::REG_FILTER, fc[i]);
            chk("conv_sel", i, 32'(conv_sel));
        end
        line_raw <= 16'h0400;
        rreg(rtd_pkg::REG_LINE, 16'h0400);
        wreg(rtd_pkg::REG_TWO_WIRE, 16'h0400);
        wreg(rtd_pkg::REG_USER_GAIN, 16'h0010);
        wreg(rtd_pkg::REG_MODE, 16'hf401);
        chk("two_wire_en", 32'h1, 32'(two_wire_en));
        chk("wdog_en", 32'h0, 32'(wdog_en));
        conv(16'h0400, 1'b0);
        chk("ohm value", 32'h64, 32'(pv));
        lnk(8'h4a, 16'h0000);
        rreg(rtd_pkg::REG_HW_OFF, 16'h0001);
        wreg(rtd_pkg::REG_UNLOCK, 16'h0000);
        rreg(rtd_pkg::REG_UNLOCK, 16'h0000);
        chk("param_commit", 32'h1, commits);
        apb(1'b0, 8'h40, 32'h0);
        chk("pslverr", 32'h1, 32'(err));
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
